// ==== sim/serial_card_host_register_control_bench.sv ====
/*
  Self-checking bench for the serial card host control logic.
  Assumes the chip model and the property checker are compiled first.
*/
`timescale 1ns/1ns
module serial_card_host_register_control_bench;
  logic                       clock, srst, host_io_data_oe, handshake_flag, irq, rx_level;
  logic                       receive_ready, transmit_ready, transmitter_empty;
  logic                       chip_clk_en, bit_rate_en;
  serial_card_pkg::host_req_t host_req;
  serial_card_pkg::chip_bus_t chip_bus;
  logic [3:0]                 select_code, modem_status;
  logic [4:0]                 modem_control_latch;
  logic [7:0]                 host_io_data_lines, chip_data_in, default_mode, got;
  int                         failures = 0;
  int                         n_tests = 0;
  int                         cycles = 0;

  serial_card_host_register_control #(.MASTER_DIV(1), .SM_DIV(1), .BIT_DIV(2)) uut (
    .clock(clock), .srst(srst), .host_req(host_req), .select_code(select_code),
    .host_io_data_lines(host_io_data_lines), .host_io_data_oe(host_io_data_oe),
    .handshake_flag(handshake_flag), .irq(irq), .chip_bus(chip_bus),
    .chip_data_in(chip_data_in), .receive_ready(receive_ready),
    .transmit_ready(transmit_ready), .transmitter_empty(transmitter_empty),
    .chip_clk_en(chip_clk_en), .bit_rate_en(bit_rate_en), .default_mode(default_mode),
    .modem_control_latch(modem_control_latch), .modem_status(modem_status));

  serial_chip_model p (
    .clock(clock), .chip_bus(chip_bus), .rx_level(rx_level), .chip_data_in(chip_data_in),
    .receive_ready(receive_ready), .transmit_ready(transmit_ready),
    .transmitter_empty(transmitter_empty));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // a hung run counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  // one strobe cycle on the host port, launched just after an edge
  task automatic acc(input logic w, input logic [2:0] r, input logic [15:0] d,
                     input logic [3:0] a);
    @(posedge clock);
    host_req <= '{a, r, d, w, !w};
    @(posedge clock);
    host_req.wr <= 1'b0;
    host_req.rd <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] r, input logic [15:0] d);
    acc(1'b1, r, d, select_code);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] r);
    acc(1'b0, r, 16'h0000, select_code);
    @(negedge clock);
    check({15'h0000, host_io_data_oe}, 16'h0001, "read enable");
    got = host_io_data_lines;
  endtask

  // bounded wait for the ready flag
  task automatic idle();
    int i;
    i = 0;
    @(negedge clock);
    while (handshake_flag !== 1'b1 && i < 300) begin
      @(negedge clock);
      i++;
    end
    check({15'h0000, handshake_flag}, 16'h0001, "flag ready");
  endtask

  task automatic conclude();
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    srst = 1'b1;
    host_req = '0;
    select_code = 4'ha;
    default_mode = 8'h4e;
    modem_status = 4'h0;
    rx_level = 1'b0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(negedge clock);
    check({14'h0000, handshake_flag, irq}, 16'h0002, "after reset");
    // foreign select code is ignored
    acc(1'b0, 3'h5, 16'h0000, 4'h3);
    @(negedge clock);
    check({15'h0000, host_io_data_oe}, 16'h0000, "foreign read");
    acc(1'b1, 3'h6, 16'h001f, 4'h3);
    @(negedge clock);
    check({11'h000, modem_control_latch}, 16'h0000, "foreign write");
    // modem lines, upper data bits ignored
    wr(3'h6, 16'hff15);
    @(negedge clock);
    check({11'h000, modem_control_latch}, 16'h0015, "modem latch");
    @(posedge clock) modem_status <= 4'ha;
    repeat (8) @(posedge clock);
    rd(3'h6);
    check({12'h000, got[3:0]}, 16'h000a, "modem status");
    // interface reset writes the two default words then drops the select
    wr(3'h5, 16'h0020);
    @(negedge clock);
    check({15'h0000, handshake_flag}, 16'h0000, "reset busy");
    idle();
    check({15'h0000, p.saw_reset}, 16'h0001, "chip reset");
    check(16'(p.log_q.size()), 16'h0002, "default count");
    check({7'h00, p.log_q[0]}, {8'h01, default_mode}, "default mode");
    check({7'h00, p.log_q[1]}, 16'h0105, "default control");
    check({15'h0000, chip_bus.cd}, 16'h0000, "select after reset");
    p.log_q.delete();
    // control path: chip reset word, mode word, control word, status read
    wr(3'h5, 16'h0001);
    repeat (2) @(negedge clock);
    check({15'h0000, chip_bus.cd}, 16'h0001, "select high");
    wr(3'h4, 16'h0040);
    idle();
    check({15'h0000, p.mode_next}, 16'h0001, "mode expected");
    wr(3'h4, 16'h004e);
    idle();
    wr(3'h4, 16'h0037);
    idle();
    check({7'h00, p.log_q[2]}, 16'h0137, "control word");
    rd(3'h4);
    idle();
    rd(3'h4);
    check({8'h00, got}, 16'h0085, "status word");
    wr(3'h5, 16'h0000);
    repeat (2) @(negedge clock);
    check({15'h0000, chip_bus.cd}, 16'h0000, "select low");
    // transmit and receive data with select low
    p.log_q.delete();
    wr(3'h4, 16'hab5a);
    @(negedge clock);
    check({15'h0000, handshake_flag}, 16'h0000, "write busy");
    idle();
    check({7'h00, p.log_q[0]}, 16'h005a, "tx byte");
    rd(3'h4);
    idle();
    rd(3'h4);
    check({8'h00, got}, 16'h003c, "rx byte");
    // interrupt modes
    wr(3'h5, 16'h0086);
    repeat (24) @(negedge clock);
    check({14'h0000, handshake_flag, irq}, 16'h0003, "tx irq");
    wr(3'h4, 16'h0011);
    @(negedge clock);
    check({15'h0000, handshake_flag}, 16'h0001, "flag kept");
    repeat (30) @(negedge clock);
    wr(3'h5, 16'h0084);
    @(negedge clock);
    check({15'h0000, irq}, 16'h0000, "rx not ready");
    rx_level <= 1'b1;
    repeat (8) @(negedge clock);
    check({15'h0000, irq}, 16'h0001, "rx irq");
    wr(3'h5, 16'h0004);
    @(negedge clock);
    check({15'h0000, irq}, 16'h0000, "gate off");
    wr(3'h5, 16'h0000);
    @(negedge clock);
    check({14'h0000, handshake_flag, irq}, 16'h0002, "irq cleared");
    conclude();
  end
endmodule

bind serial_card_host_register_control serial_card_props #(
  .MASTER_DIV(MASTER_DIV), .SM_DIV(SM_DIV), .BIT_DIV(BIT_DIV)) chk (
  .clock(clock), .srst(srst), .host_req(host_req), .select_code(select_code),
  .host_io_data_oe(host_io_data_oe), .handshake_flag(handshake_flag), .irq(irq),
  .chip_bus(chip_bus), .chip_clk_en(chip_clk_en), .modem_control_latch(modem_control_latch));

// ==== sim/serial_card_host_register_control_properties.sv ====
/*
  Concurrent checks on the ports of the serial card host control logic.
  Assumes it is bound to the top module and shares its divider parameters.
*/
`timescale 1ns/1ns
module serial_card_props #(
  parameter int MASTER_DIV = 2,
  parameter int SM_DIV     = 2,
  parameter int BIT_DIV    = 16
) (
  // clock and reset
  input wire logic                       clock,
  input wire logic                       srst,
  // host side
  input wire serial_card_pkg::host_req_t host_req,
  input wire logic [3:0]                 select_code,
  input wire logic                       host_io_data_oe,
  input wire logic                       handshake_flag,
  input wire logic                       irq,
  // chip side
  input wire serial_card_pkg::chip_bus_t chip_bus,
  input wire logic                       chip_clk_en,
  input wire logic [4:0]                 modem_control_latch
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);

  // host decode as the block should see it
  wire  hit    = host_req.peripheral_address_lines == select_code;
  wire  ctl_wr = host_req.wr && hit && host_req.reg_sel == 3'h5;
  logic [7:0] ctrl_shadow_q;
  logic [7:0] gap_q;

  // control byte shadow; bits 0 and 5 are also cleared by the sequencer
  always_ff @(posedge clock) begin
    if (srst) ctrl_shadow_q <= 8'h00;
    else if (ctl_wr) ctrl_shadow_q <= host_req.wdata[7:0];
  end

  // cycles since the last chip clock tick
  always_ff @(posedge clock) begin
    if (srst || chip_clk_en) gap_q <= 8'h00;
    else gap_q <= gap_q + 8'h01;
  end

  AST_FLAG_OFF_IN_IRQ_MODE: assert property (
    ctrl_shadow_q[2] && ctrl_shadow_q[1] |-> handshake_flag) else $error("flag low in irq mode");
  AST_NO_IRQ_WITHOUT_COND: assert property (
    !ctrl_shadow_q[2] && !ctrl_shadow_q[1] |-> !irq) else $error("irq without condition bits");
  AST_IRQ_GATED: assert property (
    !ctrl_shadow_q[7] |-> !irq) else $error("irq while gate bit clear");
  AST_CLOCK_TICKS: assert property (
    int'(gap_q) <= MASTER_DIV) else $error("chip clock tick missing");
  AST_MISS_SILENT: assert property (
    host_req.rd && !hit |=> !host_io_data_oe) else $error("answered foreign select code");
  AST_READ_ANSWERED: assert property (
    host_req.rd && hit && host_req.reg_sel inside {3'h5, 3'h6} |=> host_io_data_oe)
    else $error("read not answered");
  AST_MODEM_LATCH: assert property (
    host_req.wr && hit && host_req.reg_sel == 3'h6
    |=> modem_control_latch == $past(host_req.wdata[4:0])) else $error("modem latch wrong");
  AST_SELECT_HIGH: assert property (
    ctl_wr && host_req.wdata[0] && !host_req.wdata[5] |=> ##1 chip_bus.cd)
    else $error("select not high");
  AST_SELECT_LOW: assert property (
    ctl_wr && host_req.wdata[7:0] == 8'h00 && handshake_flag && ctrl_shadow_q[2:1] == 2'b00
    |=> ##1 !chip_bus.cd) else $error("select not low");
  AST_ONE_DIRECTION: assert property (
    !(chip_bus.wr && chip_bus.rd)) else $error("chip read and write together");
  AST_WRITE_DRIVES_BUS: assert property (
    chip_bus.wr |-> chip_bus.chip_bus_enable) else $error("write pulse without bus drive");
  AST_RESET_BUSY: assert property (
    ctl_wr && host_req.wdata[5] && host_req.wdata[2:1] == 2'b00
    |=> !handshake_flag ##[0:40] chip_bus.reset) else $error("interface reset not started");
endmodule

// ==== sim/serial_chip_model.sv ====
/*
  Behavioural serial receiver-transmitter chip facing the card logic.
  Assumes the chip bus outputs are registered on the same clock.
*/
`timescale 1ns/1ns
module serial_chip_model #(
  parameter logic [7:0] STATUS_WORD = 8'h85,
  parameter logic [7:0] RX_WORD     = 8'h3c
) (
  // clock and card side
  input  wire logic                       clock,
  input  wire serial_card_pkg::chip_bus_t chip_bus,
  input  wire logic                       rx_level,
  // chip outputs
  output logic [7:0]                      chip_data_in,
  output logic                            receive_ready,
  output logic                            transmit_ready,
  output logic                            transmitter_empty
);
  logic [8:0] log_q [$];
  logic       saw_reset = 1'b0;
  logic       mode_next = 1'b0;
  logic       wr_q      = 1'b0;
  logic [7:0] last_q    = 8'h00;
  logic [3:0] busy_q    = 4'h0;

  // log each written word; stay not-ready a while after it to act slowly
  always @(posedge clock) begin
    wr_q <= chip_bus.wr;
    if (chip_bus.reset) begin
      saw_reset <= 1'b1;
      mode_next <= 1'b1;
    end
    if (chip_bus.wr && !wr_q) begin
      log_q.push_back({chip_bus.cd, chip_bus.data});
      busy_q <= 4'hf;
      if (chip_bus.cd) mode_next <= mode_next ? 1'b0 : chip_bus.data[6];
    end else if (busy_q != 4'h0) begin
      busy_q <= busy_q - 4'h1;
    end
    if (chip_bus.rd) last_q <= chip_data_in;
  end

  // released bus shows the inverse of the last word, never a stale copy
  assign chip_data_in      = chip_bus.rd ? (chip_bus.cd ? STATUS_WORD : RX_WORD) : ~last_q;
  assign receive_ready     = rx_level;
  assign transmit_ready    = busy_q == 4'h0;
  assign transmitter_empty = busy_q == 4'h0;
endmodule

// ==== src/serial_card_defines.svh ====
/*
  Register numbers, control bit positions, default words and divider
  figures of the serial card host control logic.
  Assumes it is included by its bare name from the package and design.
*/
`ifndef SERIAL_CARD_DEFINES_SVH
`define SERIAL_CARD_DEFINES_SVH

// host register numbers
`define REG_DATA          3'h4
`define REG_CTRL          3'h5
`define REG_MODEM         3'h6
`define REG_PHASE         3'h7

// card control register bit positions
`define CTL_CD            0
`define CTL_TXI           1
`define CTL_RXI           2
`define CTL_RST           5
`define CTL_IEN           7
`define CTRL_RESET        8'h00

// modem control latch
`define MODEM_HALF        4
`define MODEM_RESET       5'h00

// fixed default control word written by the reset sequence
`define DEFAULT_CTRL_WORD 8'h05

// interface status word bit positions
`define ST_BUSY           0
`define ST_RX_READY       1
`define ST_TX_READY       2
`define ST_TX_EMPTY       3
`define ST_RD_ARMED       4
`define ST_IRQ            5

// divider defaults, counted in clock cycles or master ticks
`define MASTER_DIV        2
`define SM_DIV            2
`define BIT_DIV           16

`endif

// ==== src/serial_card_host_register_control.sv ====
/*
  Host control logic of a serial interface card: select code match,
  register strobes, transmit and receive latches, chip sequencing,
  interface reset with default words, flag and interrupt request,
  modem control and status, and the single clock divider.
  Assumes the host port is on the same clock; chip ready lines and
  modem status lines arrive asynchronously and are synchronised here.
*/
`timescale 1ns/1ns
`include "serial_card_defines.svh"

// What this block does
// - both interrupt bits set: flag suppressed, request raised on either ready
// - both interrupt bits clear: no request, flag follows read or write busy
// - chip clock, sequencer steps and bit rate all from one divider
// - register access only when address lines equal the select code
// - control register write latches low data lines into control register
// - control bit 0 set drives chip control/data select high
// - data write latches byte, then pulses chip write driving latched byte
// - control bit 0 set: data port read returns chip status word
// - data read in two phases: chip read into latch, then latch out
// - writing 0 to control register drives control/data select low
// - transmit writes use the same sequence with select held low
// - receive reads use the same two phases with select held low
// - register 6 write latches modem control onto the line outputs
// - modem status read returns present state of status lines
// - control bit 5 starts interface reset: busy and chip reset asserted
// - reset forces select high and writes switch mode word
// - reset then writes fixed default control word 5
// - reset ends by driving control/data select low
// - receive ready means character waiting, transmit ready means chip accepts
// - control bit 7 gates all requests; bits 2 and 1 pick conditions
// - handshake flag low while write busy with bit 1 clear or read busy with bit 2 clear, high otherwise
// - only low 8 data bits used; upper bits ignored
module serial_card_host_register_control #(
  parameter int MASTER_DIV = `MASTER_DIV,
  parameter int SM_DIV     = `SM_DIV,
  parameter int BIT_DIV    = `BIT_DIV
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      srst,
  // host register port
  input  wire serial_card_pkg::host_req_t host_req,
  input  wire logic [3:0]                select_code,
  output logic [7:0]                     host_io_data_lines,
  output logic                           host_io_data_oe,
  output logic                           handshake_flag,
  output logic                           irq,
  // serial chip
  output serial_card_pkg::chip_bus_t     chip_bus,
  input  wire logic [7:0]                chip_data_in,
  input  wire logic                      receive_ready,
  input  wire logic                      transmit_ready,
  input  wire logic                      transmitter_empty,
  output logic                           chip_clk_en,
  output logic                           bit_rate_en,
  // configuration switches
  input  wire logic [7:0]                default_mode,
  // modem lines
  output logic [4:0]                     modem_control_latch,
  input  wire logic [3:0]                modem_status
);

  localparam int NSYNC = 7;

  // divider state
  logic [7:0] mdiv_q;
  logic [7:0] sdiv_q;
  logic [7:0] bdiv_q;
  logic       half_q;
  logic       master_en;
  logic       sm_en;
  logic       bit_tick;

  // synchronised inputs
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] stable_q;
  logic             rx_rdy;
  logic             tx_rdy;
  logic             tx_empty;
  logic [3:0]       mstat;

  // registers and sequencer state
  logic [7:0]                   ctrl_q;
  logic [7:0]                   transmit_holding_latch;
  logic [7:0]                   receive_holding_latch;
  logic                         wr_pend_q;
  logic                         rd_pend_q;
  logic                         rst_pend_q;
  logic                         rd_armed_q;
  serial_card_pkg::chip_state_t state_q;
  serial_card_pkg::chip_state_t state_d;
  serial_card_pkg::chip_bus_t   chip_d;
  logic [7:0]                   rdata_d;

  // decoded strobes
  logic       address_match;
  logic       control_write_strobe;
  logic       data_write_strobe;
  logic       modem_write_strobe;
  logic       read_phase_strobe;
  logic       data_read;
  logic       ctrl_read;
  logic       modem_status_buffers;
  logic       any_read;
  logic [7:0] low_data;

  // busy terms and state groups
  logic in_wr;
  logic in_rd;
  logic in_rst;
  logic write_busy;
  logic read_busy;
  logic reset_busy;
  logic in_default_mode;
  logic in_default_ctrl;
  logic default_write_pulse;
  logic host_write_pulse;
  logic int_mode;
  logic flag_busy;
  logic [7:0] status_word;

  function automatic logic reg_hit(input serial_card_pkg::host_req_t r,
                                   input logic [2:0] sel,
                                   input logic match);
    reg_hit = match && (r.reg_sel == sel);
  endfunction

  // one crystal divider feeds the chip clock, step enable and bit rate
  assign master_en   = (mdiv_q == 8'(MASTER_DIV - 1));
  assign sm_en       = master_en && (sdiv_q == 8'(SM_DIV - 1));
  assign bit_tick    = master_en && (bdiv_q == 8'(BIT_DIV - 1));
  assign chip_clk_en = master_en;
  // half speed swallows every other bit rate tick
  assign bit_rate_en = bit_tick && (!modem_control_latch[`MODEM_HALF] || half_q);

  always_ff @(posedge clock) begin
    if (srst) begin
      mdiv_q <= 8'h00;
      sdiv_q <= 8'h00;
      bdiv_q <= 8'h00;
      half_q <= 1'b0;
    end else begin
      mdiv_q <= master_en ? 8'h00 : mdiv_q + 8'h01;
      if (master_en) begin
        sdiv_q <= sm_en ? 8'h00 : sdiv_q + 8'h01;
        bdiv_q <= bit_tick ? 8'h00 : bdiv_q + 8'h01;
      end
      if (bit_tick) begin
        half_q <= !half_q;
      end
    end
  end

  // three-stage synchronisers; a change counts once stages two and three agree
  assign async_in = {modem_status, transmitter_empty, transmit_ready, receive_ready};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clock) begin
        if (srst) begin
          s1_q[gi]     <= 1'b0;
          s2_q[gi]     <= 1'b0;
          s3_q[gi]     <= 1'b0;
          stable_q[gi] <= 1'b0;
        end else begin
          s1_q[gi] <= async_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            stable_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate
  assign rx_rdy   = stable_q[0];
  assign tx_rdy   = stable_q[1];
  assign tx_empty = stable_q[2];
  assign mstat    = stable_q[6:3];

  // select code match enables every register strobe
  assign address_match        = (host_req.peripheral_address_lines == select_code);
  assign low_data             = host_req.wdata[7:0];
  assign control_write_strobe = host_req.wr && reg_hit(host_req, `REG_CTRL, address_match);
  assign data_write_strobe    = host_req.wr && reg_hit(host_req, `REG_DATA, address_match);
  assign modem_write_strobe   = host_req.wr && reg_hit(host_req, `REG_MODEM, address_match);
  assign read_phase_strobe    = host_req.wr && reg_hit(host_req, `REG_PHASE, address_match);
  assign data_read            = host_req.rd && reg_hit(host_req, `REG_DATA, address_match);
  assign ctrl_read            = host_req.rd && reg_hit(host_req, `REG_CTRL, address_match);
  assign modem_status_buffers = host_req.rd && reg_hit(host_req, `REG_MODEM, address_match);
  assign any_read             = data_read || ctrl_read || modem_status_buffers;

  // state groups
  assign in_wr = (state_q == serial_card_pkg::S_WR_SETUP) ||
                 (state_q == serial_card_pkg::S_WR_PULSE) ||
                 (state_q == serial_card_pkg::S_WR_HOLD);
  assign in_rd = (state_q == serial_card_pkg::S_RD_PULSE) ||
                 (state_q == serial_card_pkg::S_RD_HOLD);
  assign in_default_mode = (state_q == serial_card_pkg::S_RST_MSET) ||
                           (state_q == serial_card_pkg::S_RST_MPULSE);
  assign in_default_ctrl = (state_q == serial_card_pkg::S_RST_CSET) ||
                           (state_q == serial_card_pkg::S_RST_CPULSE);
  assign in_rst = (state_q == serial_card_pkg::S_RST_HOLD) || in_default_mode ||
                  in_default_ctrl || (state_q == serial_card_pkg::S_RST_END);
  assign default_write_pulse = (state_q == serial_card_pkg::S_RST_MPULSE) ||
                               (state_q == serial_card_pkg::S_RST_CPULSE);
  assign host_write_pulse    = (state_q == serial_card_pkg::S_WR_PULSE);

  // busy stays up until the sequence has also dropped the select line
  assign reset_busy = rst_pend_q || in_rst;
  assign write_busy = wr_pend_q || in_wr || reset_busy;
  assign read_busy  = rd_pend_q || in_rd || reset_busy;

  // flag and interrupt: a section under interrupt gives up the flag
  assign int_mode  = ctrl_q[`CTL_TXI] && ctrl_q[`CTL_RXI];
  assign flag_busy = (!ctrl_q[`CTL_TXI] && write_busy) ||
                     (!ctrl_q[`CTL_RXI] && read_busy);
  assign handshake_flag = int_mode ? 1'b1 : !flag_busy;
  assign irq = ctrl_q[`CTL_IEN] &&
               ((ctrl_q[`CTL_RXI] && rx_rdy && !read_busy) ||
                (ctrl_q[`CTL_TXI] && tx_rdy && !write_busy));

  // sequencer: one owner of the chip bus at a time, reset first, then write
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      serial_card_pkg::S_IDLE: begin
        if (rst_pend_q) begin
          state_d = serial_card_pkg::S_RST_HOLD;
        end else if (wr_pend_q) begin
          state_d = serial_card_pkg::S_WR_SETUP;
        end else if (rd_pend_q) begin
          state_d = serial_card_pkg::S_RD_PULSE;
        end
      end
      serial_card_pkg::S_WR_SETUP:   state_d = serial_card_pkg::S_WR_PULSE;
      serial_card_pkg::S_WR_PULSE:   state_d = serial_card_pkg::S_WR_HOLD;
      serial_card_pkg::S_WR_HOLD:    state_d = serial_card_pkg::S_IDLE;
      serial_card_pkg::S_RD_PULSE:   state_d = serial_card_pkg::S_RD_HOLD;
      serial_card_pkg::S_RD_HOLD:    state_d = serial_card_pkg::S_IDLE;
      serial_card_pkg::S_RST_HOLD:   state_d = serial_card_pkg::S_RST_MSET;
      serial_card_pkg::S_RST_MSET:   state_d = serial_card_pkg::S_RST_MPULSE;
      serial_card_pkg::S_RST_MPULSE: state_d = serial_card_pkg::S_RST_CSET;
      serial_card_pkg::S_RST_CSET:   state_d = serial_card_pkg::S_RST_CPULSE;
      serial_card_pkg::S_RST_CPULSE: state_d = serial_card_pkg::S_RST_END;
      serial_card_pkg::S_RST_END:    state_d = serial_card_pkg::S_IDLE;
      default:                       state_d = serial_card_pkg::S_IDLE;
    endcase
  end

  // chip-facing signals, registered so the chip sees clean levels
  always_comb begin
    chip_d.reset = (state_q == serial_card_pkg::S_RST_HOLD);
    chip_d.wr    = host_write_pulse || default_write_pulse;
    chip_d.rd    = (state_q == serial_card_pkg::S_RD_PULSE);
    chip_d.chip_bus_enable = in_wr || in_default_mode || in_default_ctrl;
    // select follows bit 0, forced high through reset and low at its end
    if (in_rst) begin
      chip_d.cd = (state_q != serial_card_pkg::S_RST_END);
    end else begin
      chip_d.cd = ctrl_q[`CTL_CD];
    end
    if (in_default_mode) begin
      chip_d.data = default_mode;
    end else if (in_default_ctrl) begin
      chip_d.data = `DEFAULT_CTRL_WORD;
    end else if (in_wr) begin
      chip_d.data = transmit_holding_latch;
    end else begin
      chip_d.data = 8'h00;
    end
  end

  // interface status word, and read data selection
  assign status_word = {2'b00, irq, rd_armed_q, tx_empty, tx_rdy, rx_rdy,
                        (write_busy || read_busy)};
  assign rdata_d = data_read  ? receive_holding_latch :
                   ctrl_read  ? status_word :
                   {4'h0, mstat};

  // sequencer, pending requests and chip outputs
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q    <= serial_card_pkg::S_IDLE;
      chip_bus   <= '0;
      wr_pend_q  <= 1'b0;
      rd_pend_q  <= 1'b0;
      rst_pend_q <= 1'b0;
    end else begin
      chip_bus <= chip_d;
      if (sm_en) begin
        state_q <= state_d;
      end
      if (sm_en && (state_q == serial_card_pkg::S_WR_HOLD)) begin
        wr_pend_q <= 1'b0;
      end else if (data_write_strobe && !write_busy) begin
        wr_pend_q <= 1'b1;
      end
      if (sm_en && (state_q == serial_card_pkg::S_RD_HOLD)) begin
        rd_pend_q <= 1'b0;
      end else if (!read_busy && !rd_armed_q &&
                   (read_phase_strobe || data_read)) begin
        rd_pend_q <= 1'b1;
      end
      if (control_write_strobe && low_data[`CTL_RST]) begin
        rst_pend_q <= 1'b1;
      end else if (sm_en && (state_q == serial_card_pkg::S_RST_HOLD)) begin
        rst_pend_q <= 1'b0;
      end
    end
  end

  // host-written registers; a host write beats the clear at reset end
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_q              <= `CTRL_RESET;
      modem_control_latch <= `MODEM_RESET;
      transmit_holding_latch <= 8'h00;
    end else begin
      if (control_write_strobe) begin
        ctrl_q <= low_data;
      end else if (sm_en && (state_q == serial_card_pkg::S_RST_END)) begin
        ctrl_q[`CTL_CD]  <= 1'b0;
        ctrl_q[`CTL_RST] <= 1'b0;
      end
      if (modem_write_strobe) begin
        modem_control_latch <= low_data[4:0];
      end
      if (data_write_strobe && !write_busy) begin
        transmit_holding_latch <= low_data;
      end
    end
  end

  // receive latch and two-phase read tracking
  always_ff @(posedge clock) begin
    if (srst) begin
      receive_holding_latch <= 8'h00;
      rd_armed_q            <= 1'b0;
    end else begin
      // chip holds its data while the read pulse is out
      if (chip_bus.rd && !chip_d.rd) begin
        receive_holding_latch <= chip_data_in;
      end
      if (data_read && rd_armed_q && !read_busy) begin
        rd_armed_q <= 1'b0;
      end else if (!read_busy && !rd_armed_q &&
                   (read_phase_strobe || data_read)) begin
        rd_armed_q <= 1'b1;
      end
    end
  end

  // read data stand for the one cycle after the read strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      host_io_data_lines <= 8'h00;
      host_io_data_oe    <= 1'b0;
    end else begin
      host_io_data_lines <= any_read ? rdata_d : 8'h00;
      host_io_data_oe    <= any_read;
    end
  end

endmodule

// ==== src/serial_card_pkg.sv ====
/*
  Types shared by the serial card host control logic.
  Assumes serial_card_defines.svh sits on the include path.
*/
`include "serial_card_defines.svh"

package serial_card_pkg;

  // one host register access, all fields valid in the strobe cycle
  typedef struct packed {
    logic [3:0]  peripheral_address_lines;
    logic [2:0]  reg_sel;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } host_req_t;

  // signals towards the serial receiver-transmitter chip
  typedef struct packed {
    logic [7:0] data;
    logic       chip_bus_enable;
    logic       cd;
    logic       wr;
    logic       rd;
    logic       reset;
  } chip_bus_t;

  typedef enum logic [3:0] {
    S_IDLE, S_WR_SETUP, S_WR_PULSE, S_WR_HOLD, S_RD_PULSE, S_RD_HOLD,
    S_RST_HOLD, S_RST_MSET, S_RST_MPULSE, S_RST_CSET, S_RST_CPULSE,
    S_RST_END
  } chip_state_t;

endpackage
